//--- hdl/fft_port_pkg.sv
// constants, offsets and types shared by the fft host port and its routine engine
// assumes a 125 MHz system clock; instruction cycles are counted in clocks of that rate
package fft_port_pkg;
   // timing
   localparam int CLOCK_NS = 8;
   localparam int INSTR_NS = 300;
   localparam int INSTR_CLKS = (INSTR_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int INIT_CYC = 3;
   localparam int FFT_PLAIN_CYC = 3730;
   localparam int FFT_SPEC_CYC = 3862;
   localparam int FFT_CAS_CYC = 5867;
   localparam int FFT_BOTH_CYC = 5999;
   localparam int DECIMATION_PASS_ROUTINE_PLAIN_CYC = 776;
   localparam int DECIMATION_PASS_ROUTINE_CAS_CYC = 1172;
   localparam int SCALE_FIRST_CYC = 170;
   localparam int SCALE_STEP_CYC = 166;
   localparam int WINDOW_CYC = 163;
   localparam int CONJ_NS = 30000;
   localparam int CONJ_CYC = CONJ_NS / INSTR_NS;
   // byte offsets on the register bus
   localparam logic [7:0] OFS_RESET = 8'h04;
   localparam logic [7:0] OFS_UPPER = 8'h08;
   localparam logic [7:0] OFS_LOWER = 8'h0c;
   localparam logic [7:0] OFS_EXEC = 8'h10;
   localparam logic [7:0] OFS_BLOCK = 8'h24;
   localparam logic [7:0] OFS_FUNC_END = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   localparam logic [7:0] OFS_INDEX = 8'h44;
   // routine entry codes
   localparam logic [7:0] ENTRY_INIT = 8'h01;
   localparam logic [7:0] ENTRY_FFT = 8'h04;
   localparam logic [7:0] ENTRY_DECIMATION_PASS_ROUTINE = 8'hd3;
   localparam logic [7:0] ENTRY_SCALE = 8'hea;
   localparam logic [7:0] ENTRY_WINDOW = 8'hdc;
   localparam logic [7:0] ENTRY_CONJ = 8'he4;
   // ram word index is {displacement, base}
   localparam logic [6:0] IDX_SCALE_OUT = 7'h40;
   localparam logic [6:0] IDX_SCALE_IN = 7'h43;
   localparam logic [6:0] IDX_OVERFLOW_SCALING_ENABLE = 7'h44;
   localparam logic [6:0] IDX_SPECTRUM = 7'h45;
   localparam logic [1:0] DISPLACEMENT_FIELD_WINDOW = 2'h3;
   // status fields
   localparam int ST_BASE_LSB = 0;
   localparam int ST_DISPLACEMENT_FIELD_LSB = 5;
   localparam int ST_BLOCK = 8;
   localparam int ST_READ_DIR = 9;
   localparam int ST_BUSY = 10;
   localparam int ST_IRQ = 11;
   // index register fields used by the address preset
   localparam int IR_BASE_LSB = 11;
   localparam int IR_DISPLACEMENT_FIELD_LSB = 8;
   localparam logic [15:0] INDEX_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_IDLE = 3'h1,
      MODE_BLOCK = 3'h2,
      MODE_RUN = 3'h4
   } mode_t;

   typedef enum logic [6:0] {
      RT_NONE = 7'h01,
      RT_INIT = 7'h02,
      RT_FFT = 7'h04,
      RT_DECIMATION_PASS_ROUTINE = 7'h08,
      RT_SCALE = 7'h10,
      RT_WINDOW = 7'h20,
      RT_CONJ = 7'h40
   } routine_t;
endpackage

//--- hdl/engine_if.sv
// carrier between the host port and the routine engine
// assumes both ends share one clock
`timescale 1ns/1ps
interface engine_if;
   import fft_port_pkg::*;
   logic start;
   logic abort;
   routine_t routine;
   logic scaling;
   logic spectrum;
   logic [15:0] loopCount;
   logic busy;
   logic done;
   logic stepValid;
   logic [5:0] step;
   modport ctrl(output start, abort, routine, scaling, spectrum, loopCount,
      input busy, done, stepValid, step);
   modport eng(input start, abort, routine, scaling, spectrum, loopCount,
      output busy, done, stepValid, step);
endinterface

//--- hdl/routine_engine.sv
// routine engine: times each stored routine and walks the 64 data words it touches
// assumes start is a one-cycle pulse given only while not busy
`timescale 1ns/1ps
module routine_engine #(
   parameter int INSTR_CYCLE_CLOCKS = fft_port_pkg::INSTR_CLKS
) (
   input wire logic clock,
   input wire logic reset_n,
   engine_if.eng bus
);
   import fft_port_pkg::*;

   typedef struct packed {
      logic busy;
      routine_t cur;
      logic [31:0] left;
      logic [6:0] step;
      logic done;
   } eng_t;

   eng_t s;
   eng_t n;

   function automatic int instrCycles(input routine_t r, input logic scal, input logic spec,
      input logic [15:0] loops);
      int c;
      c = INIT_CYC;
      case (r)
         RT_FFT: begin
            if (scal && spec) c = FFT_BOTH_CYC;
            else if (scal) c = FFT_CAS_CYC;
            else if (spec) c = FFT_SPEC_CYC;
            else c = FFT_PLAIN_CYC;
         end
         RT_DECIMATION_PASS_ROUTINE: c = scal ? DECIMATION_PASS_ROUTINE_CAS_CYC : DECIMATION_PASS_ROUTINE_PLAIN_CYC;
         // a zero loop count is run as one pass rather than wrapping
         RT_SCALE: c = (loops == 16'h0000) ? SCALE_FIRST_CYC :
            SCALE_FIRST_CYC + SCALE_STEP_CYC * (int'(loops) - 1);
         RT_WINDOW: c = WINDOW_CYC;
         RT_CONJ: c = CONJ_CYC;
         default: c = INIT_CYC;
      endcase
      return c;
   endfunction

   always_comb begin
      n = s;
      n.done = 1'b0;
      if (bus.abort) begin
         n.busy = 1'b0;
         n.cur = RT_NONE;
      end else if (bus.start && !s.busy) begin
         n.busy = 1'b1;
         n.cur = bus.routine;
         n.step = 7'h00;
         n.left = 32'(instrCycles(bus.routine, bus.scaling, bus.spectrum, bus.loopCount)
            * INSTR_CYCLE_CLOCKS - 1);
      end else if (s.busy) begin
         if (!s.step[6]) n.step = s.step + 7'h01;
         if (s.left == 32'h0) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end else begin
            n.left = s.left - 32'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.cur <= RT_NONE;
         s.step <= 7'h40;
      end else begin
         s <= n;
      end
   end

   assign bus.busy = s.busy;
   assign bus.done = s.done;
   assign bus.step = s.step[5:0];
   // every word-walking routine lasts longer than 64 clocks, so the walk ends before done
   assign bus.stepValid = s.busy && !s.step[6] && (s.cur != RT_INIT) && (s.cur != RT_DECIMATION_PASS_ROUTINE);
endmodule

//--- hdl/fft_block_transfer_port.sv
// fft peripheral host port: function codes, block transfer sequencer, data ram,
// routine dispatch and completion request, reached over axi4-lite
// assumes one clock; the master keeps one write and one read under way at a time
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module fft_block_transfer_port #(
   parameter int INSTR_CYCLE_CLOCKS = fft_port_pkg::INSTR_CLKS
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic irqRequest
);
   import fft_port_pkg::*;

   typedef struct packed {
      mode_t mode;
      routine_t cur;
      logic start;
      logic abort;
      logic [4:0] base;
      logic [1:0] displacement_field;
      logic [15:0] index;
      logic [7:0] lowHold;
      logic [15:0] outReg;
      logic irq;
      logic readDir;
      logic awHave;
      logic [7:0] awAddr;
      logic wHave;
      logic [7:0] wByte;
      logic wLane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [127:0][15:0] ram;
   } port_t;

   port_t s;
   port_t n;

   engine_if eng();

   routine_engine #(.INSTR_CYCLE_CLOCKS(INSTR_CYCLE_CLOCKS)) u_engine (
      .clock(clock),
      .reset_n(reset_n),
      .bus(eng.eng)
   );

   function automatic logic [6:0] ramIdx(input logic [1:0] d, input logic [4:0] b);
      return {d, b};
   endfunction

   function automatic port_t advance(input port_t x);
      // the 2-bit displacement rolls from 3 to 0 by itself
      if (x.base == 5'h1f) begin
         x.base = 5'h00;
         x.displacement_field = x.displacement_field + 2'h1;
      end else begin
         x.base = x.base + 5'h01;
      end
      return x;
   endfunction

   function automatic port_t clearAll(input port_t x);
      x.mode = MODE_IDLE;
      x.base = 5'h00;
      x.displacement_field = 2'h0;
      x.index = INDEX_RESET;
      x.lowHold = 8'h00;
      x.readDir = 1'b0;
      x.irq = 1'b0;
      x.abort = 1'b1;
      return x;
   endfunction

   function automatic routine_t entryDecode(input logic [7:0] code);
      if (code == ENTRY_INIT) return RT_INIT;
      else if (code == ENTRY_FFT) return RT_FFT;
      else if (code == ENTRY_DECIMATION_PASS_ROUTINE) return RT_DECIMATION_PASS_ROUTINE;
      else if (code == ENTRY_SCALE) return RT_SCALE;
      else if (code == ENTRY_WINDOW) return RT_WINDOW;
      else if (code == ENTRY_CONJ) return RT_CONJ;
      else return RT_NONE;
   endfunction

   always_comb begin
      logic [7:0] wa;
      logic [7:0] ra;
      logic [6:0] wi;
      logic [4:0] sb;
      logic [3:0] sh;
      logic signed [31:0] prod;
      logic signed [31:0] re2;
      logic signed [31:0] im2;
      logic [31:0] v;
      wa = {s.awAddr[7:2], 2'h0};
      ra = {araddr[7:2], 2'h0};
      wi = 7'h00;
      sb = eng.step[4:0];
      sh = (|s.index[15:4]) ? 4'hf : s.index[3:0];
      prod = 32'sh0;
      re2 = 32'sh0;
      im2 = 32'sh0;
      v = 32'h0;
      n = s;
      n.start = 1'b0;
      n.abort = 1'b0;

      // word walk of the running routine
      if (eng.stepValid) begin
         wi = ramIdx({1'b0, eng.step[5]}, sb);
         case (s.cur)
            RT_CONJ: begin
               if (eng.step[5]) n.ram[wi] = 16'h0000 - s.ram[wi];
            end
            RT_SCALE: n.ram[wi] = 16'($signed(s.ram[wi]) >>> sh);
            RT_WINDOW: begin
               prod = $signed(s.ram[wi]) * $signed(s.ram[ramIdx(DISPLACEMENT_FIELD_WINDOW, sb)]);
               n.ram[wi] = prod[30:15];
            end
            RT_FFT: begin
               // spectrum reads only displacements 0/1, so it can run on the first 32 steps
               if (!eng.step[5] && eng.spectrum) begin
                  re2 = $signed(s.ram[ramIdx(2'h0, sb)]) * $signed(s.ram[ramIdx(2'h0, sb)]);
                  im2 = $signed(s.ram[ramIdx(2'h1, sb)]) * $signed(s.ram[ramIdx(2'h1, sb)]);
                  prod = (re2 >>> 1) + (im2 >>> 1);
                  n.ram[ramIdx(DISPLACEMENT_FIELD_WINDOW, sb)] = prod[30:15];
               end
            end
            default: n.ram[wi] = s.ram[wi];
         endcase
      end

      // write channel: address and data are caught in either order
      if (awvalid && !s.awHave) begin
         n.awHave = 1'b1;
         n.awAddr = awaddr;
      end
      if (wvalid && !s.wHave) begin
         n.wHave = 1'b1;
         n.wByte = wdata[7:0];
         n.wLane = wstrb[0];
      end
      if (s.bvalid && bready) n.bvalid = 1'b0;
      if (s.awHave && s.wHave && !s.bvalid) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = (wa < OFS_FUNC_END) ? RESP_OKAY : RESP_SLVERR;
         if (wa == OFS_RESET) begin
            n = clearAll(n);
         end else if (wa == OFS_UPPER && s.wLane) begin
            if (n.mode == MODE_BLOCK && !n.readDir) begin
               // upper byte closes the word; a lone upper byte lands over a zero low byte
               n.ram[ramIdx(n.displacement_field, n.base)] = {s.wByte, n.lowHold};
               n.lowHold = 8'h00;
               n = advance(n);
            end else if (n.mode == MODE_IDLE) begin
               n.index[15:8] = s.wByte;
            end
         end else if (wa == OFS_LOWER && s.wLane) begin
            if (n.mode == MODE_BLOCK && !n.readDir) n.lowHold = s.wByte;
            else if (n.mode == MODE_IDLE) n.index[7:0] = s.wByte;
         end else if (wa == OFS_EXEC && s.wLane) begin
            // execute is taken only from idle, so a block must be closed by reset first
            if (n.mode == MODE_IDLE && entryDecode(s.wByte) != RT_NONE) begin
               n.mode = MODE_RUN;
               n.cur = entryDecode(s.wByte);
               n.start = 1'b1;
            end
         end else if (wa == OFS_BLOCK) begin
            if (n.mode == MODE_IDLE) begin
               n.mode = MODE_BLOCK;
               n.readDir = 1'b0;
            end
         end
         // any other function code is acknowledged and dropped
      end

      // read channel: answered in the cycle after the address is taken
      if (s.rvalid && rready) n.rvalid = 1'b0;
      if (arvalid && !s.rvalid) begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         n.rdata = 32'h0;
         if (ra == OFS_RESET) begin
            n = clearAll(n);
         end else if (ra == OFS_UPPER) begin
            if (n.mode == MODE_BLOCK && n.readDir) begin
               n.rdata = {24'h0, n.ram[ramIdx(n.displacement_field, n.base)][15:8]};
               n = advance(n);
            end else if (n.mode == MODE_IDLE) begin
               n.rdata = {24'h0, n.outReg[15:8]};
               n.irq = 1'b0;
            end
         end else if (ra == OFS_LOWER) begin
            if (n.mode == MODE_BLOCK && n.readDir) n.rdata = {24'h0, n.ram[ramIdx(n.displacement_field, n.base)][7:0]};
            else if (n.mode == MODE_IDLE) n.rdata = {24'h0, n.outReg[7:0]};
         end else if (ra == OFS_BLOCK) begin
            if (n.mode == MODE_IDLE) begin
               n.mode = MODE_BLOCK;
               n.readDir = 1'b1;
            end
         end else if (ra == OFS_STATUS) begin
            v[ST_BASE_LSB +: 5] = s.base;
            v[ST_DISPLACEMENT_FIELD_LSB +: 2] = s.displacement_field;
            v[ST_BLOCK] = (s.mode == MODE_BLOCK);
            v[ST_READ_DIR] = s.readDir;
            v[ST_BUSY] = (s.mode == MODE_RUN);
            v[ST_IRQ] = s.irq;
            n.rdata = v;
         end else if (ra == OFS_INDEX) begin
            n.rdata = {16'h0, s.index};
         end else if (ra >= OFS_FUNC_END) begin
            n.rresp = RESP_SLVERR;
         end
      end

      // completion last, so a request set now beats a clearing read in the same cycle;
      // a reset code taken in that same cycle aborts the routine, so no request follows
      if (eng.done && s.mode == MODE_RUN && n.mode == MODE_RUN) begin
         n.mode = MODE_IDLE;
         if (s.cur == RT_INIT) begin
            n.base = s.index[IR_BASE_LSB +: 5];
            n.displacement_field = s.index[IR_DISPLACEMENT_FIELD_LSB +: 2];
         end else begin
            n.irq = 1'b1;
         end
         if (s.cur == RT_FFT || s.cur == RT_DECIMATION_PASS_ROUTINE) begin
            // no overflow correction is modelled, so the output scale equals the input one
            n.outReg = s.ram[IDX_SCALE_IN];
            n.ram[IDX_SCALE_OUT] = s.ram[IDX_SCALE_IN];
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.mode <= MODE_IDLE;
         s.cur <= RT_NONE;
      end else begin
         s <= n;
      end
   end

   assign eng.start = s.start;
   assign eng.abort = s.abort;
   assign eng.routine = s.cur;
   // option words are only read, never rewritten
   assign eng.scaling = s.ram[IDX_OVERFLOW_SCALING_ENABLE][15];
   assign eng.spectrum = |s.ram[IDX_SPECTRUM];
   assign eng.loopCount = s.index;

   assign awready = !s.awHave;
   assign wready = !s.wHave;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = !s.rvalid;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign irqRequest = s.irq;
endmodule

//--- tb/fft_port_assertions.sv
// bus and completion checks for the fft host port
// assumes one clock domain; bound onto the top module at the foot
`timescale 1ns/1ps
module fft_port_assertions (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic irqRequest
);
   import fft_port_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence wrTaken;
      awvalid && awready && wvalid && wready && !bvalid;
   endsequence
   sequence answerLater;
      ##1 !bvalid ##1 bvalid;
   endsequence
   chk_write_answer: assert property (wrTaken |-> answerLater)
      else $error("write answer late");
   chk_unmapped_err: assert property
      (wrTaken ##0 (awaddr >= OFS_STATUS) |-> ##2 bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   chk_reset_irq: assert property
      (wrTaken ##0 (awaddr[7:2] == OFS_RESET[7:2]) |-> ##2 !irqRequest)
      else $error("request survives reset code");
   chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   chk_ar_refused: assert property (rvalid |-> !arready)
      else $error("read taken while answer pending");
   chk_read_latency: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_err_data: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
      else $error("refused read carries data");
endmodule
bind fft_block_transfer_port fft_port_assertions u_fft_port_assertions (
   .clock(clock), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
   .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .rresp(rresp), .irqRequest(irqRequest));

//--- tb/host_master.sv
// host processor model: axi4-lite master, one write and one read at a time
// assumes the bench calls its tasks; slow holds back bready and rready
`timescale 1ns/1ps
module host_master (
   input wire logic clock,
   output logic awvalid,
   input wire logic awready,
   output logic [7:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   output logic arvalid,
   input wire logic arready,
   output logic [7:0] araddr,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   // minimum access spacing, about 98 ns at this clock, rounded up
   localparam int GAP_CLKS = 13;
   localparam int WAIT_MAX = 200;
   logic slow = 1'b0;
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
   end
   // released payload is inverted so a stale value never looks valid
   task automatic writeReg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      repeat (GAP_CLKS) @(posedge clock);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= {2'b11, !slow};
      for (n = 0; n < WAIT_MAX; n++) begin
         @(posedge clock);
         if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
         if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~d};
         if (bvalid && bready) break;
         bready <= bready || bvalid;
      end
      r = bresp;
      bready <= 1'b0;
      if (n == WAIT_MAX) fft_block_transfer_port_tb.hang("write answer");
   endtask
   task automatic readReg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      repeat (GAP_CLKS) @(posedge clock);
      araddr <= a;
      {arvalid, rready} <= {1'b1, !slow};
      for (n = 0; n < WAIT_MAX; n++) begin
         @(posedge clock);
         if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
         if (rvalid && rready) break;
         rready <= rready || rvalid;
      end
      {d, r} = {rdata, rresp};
      rready <= 1'b0;
      if (n == WAIT_MAX) fft_block_transfer_port_tb.hang("read answer");
   endtask
endmodule

//--- tb/fft_block_transfer_port_tb.sv
// self-checking bench for the fft host port: block transfers, routines, bus refusals
// assumes host_master drives the bus and the checker is bound from its own file
`timescale 1ns/1ps
module fft_block_transfer_port_tb;
   import fft_port_pkg::*;
   logic clock, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irqRequest;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int num_errors, check_count;
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   fft_block_transfer_port #(.INSTR_CYCLE_CLOCKS(1)) u_fft_block_transfer_port (
      .clock(clock), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .irqRequest(irqRequest));
   host_master u_host_master (
      .clock(clock), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic hang(input string what);
      check(32'h0, 32'h1, what);
      give_verdict();
   endtask
   // words from 60 on go in by the upper port alone, so their low byte is 00
   function automatic logic [15:0] wordOf(input int k);
      if (k >= 8'h60) return {k[7:0] ^ 8'h3c, 8'h00};
      if (k == IDX_OVERFLOW_SCALING_ENABLE || k == IDX_SPECTRUM) return 16'h0000;
      return {k[7:0] ^ 8'ha5, k[7:0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      u_host_master.writeReg(a, {24'h0, d}, r);
      check(r, RESP_OKAY, "wr resp");
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      u_host_master.readReg(a, d, r);
      check(r, RESP_OKAY, "rd resp");
   endtask
   task automatic waitIrq(output int n);
      for (n = 0; n < 8000; n++) begin
         @(posedge clock);
         if (irqRequest === 1'b1) break;
      end
      if (n == 8000) hang("request wait");
   endtask
   task automatic test_write();
      logic [31:0] s;
      logic [15:0] w;
      rd(OFS_STATUS, s);
      check(s, 32'h0, "status at reset");
      wr(OFS_RESET, 8'h00);
      wr(OFS_BLOCK, 8'h00);
      for (int k = 0; k < 128; k++) begin
         w = wordOf(k);
         if (k < 8'h60) wr(OFS_LOWER, w[7:0]);
         wr(OFS_UPPER, w[15:8]);
         if (k == 31) rd(OFS_STATUS, s);
         if (k == 31) check(s[11:0], 12'h120, "after 1f.0");
      end
      rd(OFS_STATUS, s);
      check(s[11:0], 12'h100, "after 1f.3");
      $display("test_write done");
   endtask
   task automatic test_read();
      logic [31:0] s, lo, hi;
      wr(OFS_RESET, 8'h00);
      rd(OFS_BLOCK, s);
      wr(OFS_BLOCK, 8'h00);
      rd(OFS_STATUS, s);
      check(s[11:0], 12'h300, "read latched");
      for (int k = 0; k < 128; k++) begin
         rd(OFS_LOWER, lo);
         rd(OFS_UPPER, hi);
         check({hi[7:0], lo[7:0]}, wordOf(k), "ram word");
      end
      rd(OFS_STATUS, s);
      check(s[11:0], 12'h300, "read wrap");
      wr(OFS_RESET, 8'h00);
      rd(OFS_STATUS, s);
      check(s, 32'h0, "status reset code");
      $display("test_read done");
   endtask
   task automatic test_fft();
      int n;
      logic [31:0] d;
      logic [15:0] sc;
      sc = wordOf(IDX_SCALE_IN);
      wr(OFS_EXEC, ENTRY_FFT);
      waitIrq(n);
      check(n >= FFT_PLAIN_CYC && n <= FFT_PLAIN_CYC + 4, 1'b1, "fft time");
      rd(OFS_LOWER, d);
      check(d[7:0], sc[7:0], "scale low");
      check(irqRequest, 1'b1, "request held");
      rd(OFS_UPPER, d);
      check(d[7:0], sc[15:8], "scale high");
      check(irqRequest, 1'b0, "request read");
      $display("test_fft done");
   endtask
   task automatic test_routines();
      logic [7:0] ent [4] = '{ENTRY_DECIMATION_PASS_ROUTINE, ENTRY_SCALE, ENTRY_WINDOW, ENTRY_CONJ};
      int dur [4] = '{DECIMATION_PASS_ROUTINE_PLAIN_CYC, SCALE_FIRST_CYC, WINDOW_CYC, CONJ_CYC};
      int n;
      logic [31:0] s;
      wr(OFS_UPPER, 8'h00);
      wr(OFS_LOWER, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_EXEC, ent[i]);
         rd(OFS_STATUS, s);
         check(s[ST_BUSY], 1'b1, "busy");
         waitIrq(n);
         check(n + 20 >= dur[i] && n <= dur[i], 1'b1, "time");
         rd(OFS_UPPER, s);
         check(irqRequest, 1'b0, "request read");
      end
      wr(OFS_UPPER, 8'h9a);
      wr(OFS_EXEC, ENTRY_INIT);
      rd(OFS_STATUS, s);
      check(s[11:0], 12'h053, "preset");
      wr(OFS_EXEC, ENTRY_CONJ);
      waitIrq(n);
      wr(OFS_RESET, 8'h00);
      check(irqRequest, 1'b0, "request reset");
      rd(OFS_INDEX, s);
      check(s, 32'h0, "index reset");
      $display("test_routines done");
   endtask
   task automatic preset(input logic [15:0] ix);
      wr(OFS_RESET, 8'h00);
      wr(OFS_UPPER, ix[15:8]);
      wr(OFS_LOWER, ix[7:0]);
      wr(OFS_EXEC, ENTRY_INIT);
   endtask
   // one known word is negated in place, then both options run the transform
   task automatic test_options();
      int n;
      logic [31:0] lo, hi;
      preset(16'h0100);
      wr(OFS_BLOCK, 8'h00);
      wr(OFS_LOWER, 8'h34);
      wr(OFS_UPPER, 8'h12);
      wr(OFS_RESET, 8'h00);
      wr(OFS_EXEC, ENTRY_CONJ);
      waitIrq(n);
      preset(16'h0100);
      rd(OFS_BLOCK, lo);
      rd(OFS_LOWER, lo);
      rd(OFS_UPPER, hi);
      check({hi[7:0], lo[7:0]}, 16'hedcc, "conjugate word");
      preset(16'h2200);
      wr(OFS_BLOCK, 8'h00);
      wr(OFS_LOWER, 8'h00);
      wr(OFS_UPPER, 8'h80);
      wr(OFS_UPPER, 8'h01);
      wr(OFS_RESET, 8'h00);
      wr(OFS_EXEC, ENTRY_FFT);
      waitIrq(n);
      check(n >= FFT_BOTH_CYC && n <= FFT_BOTH_CYC + 4, 1'b1, "fft options");
      wr(OFS_RESET, 8'h00);
      check(irqRequest, 1'b0, "options request reset");
      $display("test_options done");
   endtask
   task automatic test_misc();
      logic [31:0] s;
      logic [1:0] r;
      u_host_master.slow = 1'b1;
      wr(8'h14, 8'h55);
      wr(OFS_EXEC, 8'h07);
      rd(OFS_STATUS, s);
      check(s, 32'h0, "undefined codes");
      u_host_master.writeReg(8'h48, 32'h0, r);
      check(r, RESP_SLVERR, "unmapped wr");
      u_host_master.readReg(8'h50, s, r);
      check(r, RESP_SLVERR, "unmapped rd");
      check(s, 32'h0, "unmapped data");
      u_host_master.slow = 1'b0;
      $display("test_misc done");
   endtask
   initial begin
      reset_n = 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      test_write();
      test_read();
      test_fft();
      test_routines();
      test_options();
      test_misc();
      give_verdict();
   end
endmodule
